// ---- inc/dma_port_pkg.sv ----
`default_nettype none
package dma_port_pkg;
  // Port map: upper nibble selects the block, lower nibble the register
  localparam logic [3:0] PORT_HI        = 4'hB;
  localparam logic [7:0] PORT_CMD       = 8'hB8;
  localparam logic [7:0] PORT_REQ       = 8'hB9;
  localparam logic [7:0] PORT_MASK_ONE  = 8'hBA;
  localparam logic [7:0] PORT_MODE      = 8'hBB;
  localparam logic [7:0] PORT_FF_CLR    = 8'hBC;
  localparam logic [7:0] PORT_MCLR      = 8'hBD;
  localparam logic [7:0] PORT_MASK_CLR  = 8'hBE;
  localparam logic [7:0] PORT_MASK_ALL  = 8'hBF;
  // Index bit 3 low means a channel address/count port
  localparam int         IDX_REG_BIT    = 3;
  localparam int         IDX_CNT_BIT    = 0;

  // Mode word: bits 1:0 pick the channel, bits 7:2 are stored
  localparam int         MODE_LSB       = 2;
  localparam int         MODE_AUTO      = 2;
  localparam int         MODE_DEC       = 3;
  localparam logic [1:0] TT_WRITE       = 2'h1;
  localparam logic [1:0] TT_READ        = 2'h2;
  localparam logic [1:0] XM_DEMAND      = 2'h0;
  localparam logic [1:0] XM_SINGLE      = 2'h1;
  localparam logic [1:0] XM_BLOCK       = 2'h2;
  // Request and single mask words: bit 2 set/clear, bits 1:0 channel
  localparam int         SEL_SET_BIT    = 2;
  // Command bits
  localparam int         CMD_MEM2MEM    = 0;
  localparam int         CMD_DISABLE    = 2;
  // Reset and fill values, terminal count value and address/count step
  localparam logic [3:0] MASK_ALL_SET   = 4'hF;
  localparam logic [7:0] RD_UNMAPPED    = 8'h00;
  localparam logic [15:0] CNT_LAST      = 16'h0000;
  localparam logic [15:0] ADDR_STEP     = 16'h0001;

  typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_MM_RD, ST_MM_WR} eng_t;

  typedef struct packed {
    logic [15:0] base_addr;
    logic [15:0] base_cnt;
    logic [15:0] addr;
    logic [15:0] cnt;
  } chan_state_t;

  typedef struct packed {
    logic [7:0]      cmd;
    logic [3:0][5:0] mode;
    logic [3:0]      sw_req;
    logic [3:0]      mask;
    logic [3:0]      tc;
    logic [7:0]      temp;
    logic            ff;
    eng_t            st;
    logic [1:0]      chan;
    logic [3:0]      ack;
    logic            eop;
    logic            mem_rd;
    logic            mem_wr;
    logic [15:0]     mem_addr;
    logic [7:0]      rdata;
  } dma_state_t;
endpackage : dma_port_pkg
`default_nettype wire

// ---- rtl/dma_chan_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module dma_chan_regs (
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  input  wire logic        clear_i,
  input  wire logic        wr_addr_i,
  input  wire logic        wr_cnt_i,
  input  wire logic        hi_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        step_i,
  input  wire logic        dec_i,
  input  wire logic        reload_i,
  output logic      [15:0] addr_o,
  output logic      [15:0] cnt_o
);
  dma_port_pkg::chan_state_t st_q;
  dma_port_pkg::chan_state_t st_d;

  // Host byte loads hit base and current copies together
  always_comb begin
    st_d = st_q;
    if (wr_addr_i) begin
      if (hi_i) begin
        st_d.base_addr[15:8] = wdata_i;
        st_d.addr[15:8]      = wdata_i;
      end else begin
        st_d.base_addr[7:0]  = wdata_i;
        st_d.addr[7:0]       = wdata_i;
      end
    end
    if (wr_cnt_i) begin
      if (hi_i) begin
        st_d.base_cnt[15:8] = wdata_i;
        st_d.cnt[15:8]      = wdata_i;
      end else begin
        st_d.base_cnt[7:0]  = wdata_i;
        st_d.cnt[7:0]       = wdata_i;
      end
    end
    // Autoinit restores the programmed values after the last byte
    if (step_i) begin
      st_d.addr = dec_i ? st_q.addr - dma_port_pkg::ADDR_STEP
                        : st_q.addr + dma_port_pkg::ADDR_STEP;
      st_d.cnt  = st_q.cnt - dma_port_pkg::ADDR_STEP;
      if (reload_i) begin
        st_d.addr = st_q.base_addr;
        st_d.cnt  = st_q.base_cnt;
      end
    end
    if (clear_i) begin
      st_d = '0;
    end
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      st_q <= '0;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  assign addr_o = st_q.addr;
  assign cnt_o  = st_q.cnt;
endmodule : dma_chan_regs
`default_nettype wire

// ---- rtl/dma_port_if.sv ----
// Overview of operation
// - Four channels, demand/single/block, read/write types
// - Memory-to-memory moves through temporary byte
// - Sixteen ports decoded, base through top
// - Command register loaded by write to B8
// - Mode write at BB, low bits pick channel
// - Software request bits set/cleared via B9
// - Software request served only in block mode
// - Set mask bit ignores hardware request line
// - End of process masks non-autoinit channel
// - Reset sets all mask bits
// - Single-bit and all-bit mask instructions
// - Temporary byte readable at BD until reset
// - Write to BC clears byte pointer
// - Write to BD acts as full reset
// - Status read at B8: terminal count, pending
// - Per-channel address and count registers
`timescale 1ns/1ps
`default_nettype none
module dma_port_if (
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  input  wire logic [7:0]  io_addr_i,
  input  wire logic        io_wr_i,
  input  wire logic        io_rd_i,
  input  wire logic [7:0]  io_wdata_i,
  output logic      [7:0]  io_rdata_o,
  input  wire logic [3:0]  channel_request_line_i,
  output logic      [3:0]  channel_ack_o,
  output logic             end_of_process_n_o,
  output logic      [15:0] mem_addr_o,
  output logic             mem_rd_o,
  output logic             mem_wr_o,
  output logic      [7:0]  mem_wdata_o,
  input  wire logic [7:0]  mem_rdata_i
);
  dma_port_pkg::dma_state_t st_q;
  dma_port_pkg::dma_state_t st_d;

  logic [3:0]       ch_wr_addr;
  logic [3:0]       ch_wr_cnt;
  logic [3:0]       ch_step;
  logic [3:0]       ch_reload;
  logic [3:0][15:0] ch_addr;
  logic [3:0][15:0] ch_cnt;
  logic             mclr;
  logic             hit;
  logic [3:0]       idx;
  logic [3:0]       blk;
  logic [3:0]       svc;
  logic [3:0]       pending;
  logic [1:0]       pick;
  logic [15:0]      rd_word;

  // Port decode; the direction picks between shared ports
  assign hit  = (io_addr_i[7:4] == dma_port_pkg::PORT_HI);
  assign idx  = io_addr_i[3:0];
  assign mclr = io_wr_i && (io_addr_i == dma_port_pkg::PORT_MCLR);
  assign rd_word = idx[dma_port_pkg::IDX_CNT_BIT] ? ch_cnt[idx[2:1]]
                                                  : ch_addr[idx[2:1]];

  // Serviceable requests, lowest channel wins
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      blk[n] = (st_q.mode[n][5:4] == dma_port_pkg::XM_BLOCK);
    end
    svc     = (channel_request_line_i & ~st_q.mask)
            | (st_q.sw_req & blk);
    pending = channel_request_line_i | st_q.sw_req;
    pick    = 2'h0;
    for (int n = 3; n >= 0; n--) begin
      if (svc[n]) begin
        pick = 2'(n);
      end
    end
  end

  // Register access, then engine, then master clear on top
  always_comb begin
    st_d        = st_q;
    st_d.ack    = 4'h0;
    st_d.eop    = 1'b0;
    st_d.mem_rd = 1'b0;
    st_d.mem_wr = 1'b0;
    ch_wr_addr  = 4'h0;
    ch_wr_cnt   = 4'h0;
    ch_step     = 4'h0;
    ch_reload   = 4'h0;
    // Host reads answer on the next edge
    if (io_rd_i && hit) begin
      st_d.rdata = dma_port_pkg::RD_UNMAPPED;
      if (!idx[dma_port_pkg::IDX_REG_BIT]) begin
        st_d.rdata = st_q.ff ? rd_word[15:8] : rd_word[7:0];
        st_d.ff    = !st_q.ff;
      end else if (io_addr_i == dma_port_pkg::PORT_CMD) begin
        st_d.rdata = {pending, st_q.tc};
        st_d.tc    = 4'h0;
      end else if (io_addr_i == dma_port_pkg::PORT_MCLR) begin
        st_d.rdata = st_q.temp;
      end
    end
    // Host writes; the byte pointer alternates low then high
    if (io_wr_i && hit) begin
      if (!idx[dma_port_pkg::IDX_REG_BIT]) begin
        ch_wr_addr[idx[2:1]] = !idx[dma_port_pkg::IDX_CNT_BIT];
        ch_wr_cnt[idx[2:1]]  = idx[dma_port_pkg::IDX_CNT_BIT];
        st_d.ff = !st_q.ff;
      end
      case (io_addr_i)
        dma_port_pkg::PORT_CMD:      st_d.cmd = io_wdata_i;
        dma_port_pkg::PORT_REQ:      st_d.sw_req[io_wdata_i[1:0]] =
                                       io_wdata_i[dma_port_pkg::SEL_SET_BIT];
        dma_port_pkg::PORT_MASK_ONE: st_d.mask[io_wdata_i[1:0]] =
                                       io_wdata_i[dma_port_pkg::SEL_SET_BIT];
        dma_port_pkg::PORT_MODE:     st_d.mode[io_wdata_i[1:0]] =
                                       io_wdata_i[7:dma_port_pkg::MODE_LSB];
        dma_port_pkg::PORT_FF_CLR:   st_d.ff = 1'b0;
        dma_port_pkg::PORT_MASK_CLR: st_d.mask = 4'h0;
        dma_port_pkg::PORT_MASK_ALL: st_d.mask = io_wdata_i[3:0];
        default: ;
      endcase
    end
    // Transfer engine; its sets land after host clears so they win
    case (st_q.st)
      dma_port_pkg::ST_IDLE: begin
        if (!st_q.cmd[dma_port_pkg::CMD_DISABLE]) begin
          if (st_q.cmd[dma_port_pkg::CMD_MEM2MEM] && svc[0]) begin
            st_d.st   = dma_port_pkg::ST_MM_RD;
            st_d.chan = 2'h0;
          end else if (svc != 4'h0) begin
            st_d.st   = dma_port_pkg::ST_XFER;
            st_d.chan = pick;
          end
        end
      end
      dma_port_pkg::ST_XFER: begin
        // One byte per cycle; strobes show one edge later
        st_d.ack[st_q.chan] = 1'b1;
        st_d.mem_addr = ch_addr[st_q.chan];
        st_d.mem_rd = (st_q.mode[st_q.chan][1:0] == dma_port_pkg::TT_READ);
        st_d.mem_wr = (st_q.mode[st_q.chan][1:0] == dma_port_pkg::TT_WRITE);
        ch_step[st_q.chan] = 1'b1;
        case (st_q.mode[st_q.chan][5:4])
          dma_port_pkg::XM_SINGLE: st_d.st = dma_port_pkg::ST_IDLE;
          dma_port_pkg::XM_DEMAND:
            if (!svc[st_q.chan]) begin
              st_d.st = dma_port_pkg::ST_IDLE;
            end
          dma_port_pkg::XM_BLOCK:  ;
          default: st_d.st = dma_port_pkg::ST_IDLE;
        endcase
        if (ch_cnt[st_q.chan] == dma_port_pkg::CNT_LAST) begin
          st_d.st              = dma_port_pkg::ST_IDLE;
          st_d.tc[st_q.chan]   = 1'b1;
          st_d.eop             = 1'b1;
          st_d.sw_req[st_q.chan] = 1'b0;
          if (st_q.mode[st_q.chan][dma_port_pkg::MODE_AUTO]) begin
            ch_reload[st_q.chan] = 1'b1;
          end else begin
            st_d.mask[st_q.chan] = 1'b1;
          end
        end
      end
      dma_port_pkg::ST_MM_RD: begin
        // Source byte read from channel zero's address
        st_d.mem_addr = ch_addr[0];
        st_d.mem_rd   = 1'b1;
        ch_step[0]    = 1'b1;
        st_d.st       = dma_port_pkg::ST_MM_WR;
      end
      dma_port_pkg::ST_MM_WR: begin
        // Read strobe is on now, so the source byte is valid
        st_d.temp     = mem_rdata_i;
        st_d.mem_addr = ch_addr[1];
        st_d.mem_wr   = 1'b1;
        ch_step[1]    = 1'b1;
        st_d.st       = dma_port_pkg::ST_MM_RD;
        if (ch_cnt[1] == dma_port_pkg::CNT_LAST) begin
          st_d.st     = dma_port_pkg::ST_IDLE;
          st_d.tc[1]  = 1'b1;
          st_d.eop    = 1'b1;
          st_d.sw_req[0] = 1'b0;
          if (st_q.mode[1][dma_port_pkg::MODE_AUTO]) begin
            ch_reload[1] = 1'b1;
          end else begin
            st_d.mask[1] = 1'b1;
          end
        end
      end
      default: st_d.st = dma_port_pkg::ST_IDLE;
    endcase
    // Master clear behaves like reset regardless of data
    if (mclr) begin
      st_d      = '0;
      st_d.mask = dma_port_pkg::MASK_ALL_SET;
    end
  end

  // State register; reset masks every hardware request
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      st_q      <= '0;
      st_q.mask <= dma_port_pkg::MASK_ALL_SET;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  // One register set per channel
  for (genvar g = 0; g < 4; g++) begin : g_chan
    dma_chan_regs u_regs (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .ce_i      (ce_i),
      .clear_i   (mclr),
      .wr_addr_i (ch_wr_addr[g]),
      .wr_cnt_i  (ch_wr_cnt[g]),
      .hi_i      (st_q.ff),
      .wdata_i   (io_wdata_i),
      .step_i    (ch_step[g]),
      .dec_i     (st_q.mode[g][dma_port_pkg::MODE_DEC]),
      .reload_i  (ch_reload[g]),
      .addr_o    (ch_addr[g]),
      .cnt_o     (ch_cnt[g])
    );
  end

  // Outputs straight from flops
  assign io_rdata_o         = st_q.rdata;
  assign channel_ack_o      = st_q.ack;
  assign end_of_process_n_o = !st_q.eop;
  assign mem_addr_o         = st_q.mem_addr;
  assign mem_rd_o           = st_q.mem_rd;
  assign mem_wr_o           = st_q.mem_wr;
  assign mem_wdata_o        = st_q.temp;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence seq_mm_read;
    ce_i && st_q.st == dma_port_pkg::ST_MM_RD ##1 mem_rd_o;
  endsequence
  sequence seq_mm_write;
    mem_wr_o && mem_wdata_o == $past(mem_rdata_i, 1);
  endsequence

  chk_cmd_load: assert property (
    ce_i && io_wr_i && io_addr_i == dma_port_pkg::PORT_CMD
    |=> st_q.cmd == $past(io_wdata_i))
    else $error("command register not loaded");
  chk_mode_lane: assert property (
    ce_i && io_wr_i && io_addr_i == dma_port_pkg::PORT_MODE
    |=> st_q.mode[$past(io_wdata_i[1:0])] == $past(io_wdata_i[7:2]))
    else $error("mode register lane wrong");
  chk_master_clear: assert property (
    ce_i && io_wr_i && io_addr_i == dma_port_pkg::PORT_MCLR
    |=> st_q.mask == 4'hF && st_q.cmd == 8'h00 && !st_q.ff)
    else $error("master clear incomplete");
  chk_ptr_clear: assert property (
    ce_i && io_wr_i && io_addr_i == dma_port_pkg::PORT_FF_CLR
    |=> !st_q.ff)
    else $error("byte pointer not cleared");
  chk_status_read: assert property (
    ce_i && io_rd_i && io_addr_i == dma_port_pkg::PORT_CMD
    |=> io_rdata_o == {$past(pending), $past(st_q.tc)})
    else $error("status word wrong");
  chk_temp_read: assert property (
    ce_i && io_rd_i && io_addr_i == dma_port_pkg::PORT_MCLR
    |=> io_rdata_o == $past(st_q.temp))
    else $error("temporary byte not returned");
  chk_masked_idle: assert property (
    ce_i && st_q.st == dma_port_pkg::ST_IDLE && svc == 4'h0 && !mclr
    |=> st_q.st == dma_port_pkg::ST_IDLE)
    else $error("masked or non-block request started");
  chk_eop_mask: assert property (
    ce_i && !mclr && st_q.st == dma_port_pkg::ST_XFER
    && ch_cnt[st_q.chan] == 16'h0000
    && !st_q.mode[st_q.chan][dma_port_pkg::MODE_AUTO]
    |=> !end_of_process_n_o && st_q.mask[$past(st_q.chan)])
    else $error("end of process did not mask channel");
  chk_single_mask: assert property (
    ce_i && io_wr_i && io_addr_i == dma_port_pkg::PORT_MASK_ONE
    && st_q.st == dma_port_pkg::ST_IDLE
    |=> st_q.mask[$past(io_wdata_i[1:0])] == $past(io_wdata_i[2]))
    else $error("single mask bit wrong");
  chk_mm_pair: assert property (
    seq_mm_read ##0 (ce_i && !mclr) |=> seq_mm_write)
    else $error("memory move byte not forwarded");
endmodule : dma_port_if
`default_nettype wire

// ---- testbench/dma_far_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dma_far_model (
  input  wire logic        ref_clk_i,
  input  wire logic [3:0]  want_i,
  output logic      [3:0]  request_o,
  input  wire logic [15:0] mem_addr_i,
  input  wire logic        mem_rd_i,
  input  wire logic        mem_wr_i,
  input  wire logic [7:0]  mem_wdata_i,
  output logic      [7:0]  mem_rdata_o,
  output logic      [7:0]  wr_cnt_o,
  output logic      [15:0] wr_addr_o,
  output logic      [7:0]  wr_data_o
);
  logic [7:0] churn_q;

  // Peripherals hold their request level as long as the bench asks
  assign request_o = want_i;

  // Read data valid only in the strobe cycle; churns so stale use shows
  assign mem_rdata_o = mem_rd_i ? (mem_addr_i[7:0] ^ 8'h3C) : churn_q;

  initial begin
    churn_q   = 8'h00;
    wr_cnt_o  = 8'h00;
    wr_addr_o = 16'h0000;
    wr_data_o = 8'h00;
  end

  // Log memory writes so the bench can see where moved bytes landed
  always @(posedge ref_clk_i) begin
    churn_q <= churn_q + 8'h5B;
    if (mem_wr_i === 1'b1) begin
      wr_cnt_o  <= wr_cnt_o + 8'h01;
      wr_addr_o <= mem_addr_i;
      wr_data_o <= mem_wdata_i;
    end
  end
endmodule : dma_far_model
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  logic        ref_clk, resetn, io_wr, io_rd, mm_on, rt;
  logic        mem_rd, mem_wr, eop_n;
  logic [7:0]  io_addr, io_wdata, io_rdata, mem_rdata, mem_wdata;
  logic [7:0]  wr_cnt, wr_data, er, w0;
  logic [15:0] mem_addr, wr_addr, a;
  logic [3:0]  want, req, ack;
  logic [22:0] ex;
  logic [1:0]  tt;
  int          error_cnt, check_count, k;
  logic [7:0]  rq[$];
  logic [22:0] xq[$];

  dma_port_if dut_u (.ref_clk_i(ref_clk), .resetn_i(resetn), .ce_i(1'b1),
    .io_addr_i(io_addr), .io_wr_i(io_wr), .io_rd_i(io_rd),
    .io_wdata_i(io_wdata), .io_rdata_o(io_rdata),
    .channel_request_line_i(req), .channel_ack_o(ack),
    .end_of_process_n_o(eop_n), .mem_addr_o(mem_addr), .mem_rd_o(mem_rd),
    .mem_wr_o(mem_wr), .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata));
  dma_far_model far_u (.ref_clk_i(ref_clk), .want_i(want), .request_o(req),
    .mem_addr_i(mem_addr), .mem_rd_i(mem_rd), .mem_wr_i(mem_wr),
    .mem_wdata_i(mem_wdata), .mem_rdata_o(mem_rdata), .wr_cnt_o(wr_cnt),
    .wr_addr_o(wr_addr), .wr_data_o(wr_data));

  always #4 ref_clk = ~ref_clk;

  // Monitor: oldest note answers each read result and each serviced byte
  always @(posedge ref_clk) begin
    rt = io_rd === 1'b1 && io_addr[7:4] == 4'hB;
    #2;
    if (rt) begin
      er = (rq.size() != 0) ? rq.pop_front() : 8'hXX;
      `CHK(io_rdata, er)
    end
    if (|ack && !mm_on) begin
      ex = (xq.size() != 0) ? xq.pop_front() : 23'hXXXXXX;
      `CHK({ack, mem_rd, mem_wr, eop_n, mem_addr}, ex)
    end
  end

  // One host cycle; reads note the expected byte (in-range only)
  task automatic acc(input logic r, input logic [7:0] ad, input logic [7:0] d);
    if (r && ad[7:4] == 4'hB) rq.push_back(d);
    @(posedge ref_clk) #1;
    io_addr = ad;
    io_wdata = d;
    io_rd = r;
    io_wr = !r;
    @(posedge ref_clk) #1;
    io_rd = 1'b0;
    io_wr = 1'b0;
  endtask : acc

  // Junk low byte first: only a working pointer clear drops it
  task automatic prog(input logic [1:0] ch, input logic [1:0] xm,
    input logic [1:0] ty, input logic au, input logic [15:0] ba,
    input logic [7:0] n);
    acc(0, dma_port_pkg::PORT_FF_CLR, 8'h00);
    acc(0, {4'hB, 1'b0, ch, 1'b0}, 8'hEE);
    acc(0, dma_port_pkg::PORT_FF_CLR, 8'h00);
    acc(0, {4'hB, 1'b0, ch, 1'b0}, ba[7:0]);
    acc(0, {4'hB, 1'b0, ch, 1'b0}, ba[15:8]);
    acc(0, {4'hB, 1'b0, ch, 1'b1}, n);
    acc(0, {4'hB, 1'b0, ch, 1'b1}, 8'h00);
    acc(0, dma_port_pkg::PORT_FF_CLR, 8'h00);
    acc(1, {4'hB, 1'b0, ch, 1'b0}, ba[7:0]);
    acc(1, {4'hB, 1'b0, ch, 1'b0}, ba[15:8]);
    acc(0, dma_port_pkg::PORT_MODE, {xm, 1'b0, au, ty, ch});
  endtask : prog

  // Hardware request held until the last byte, then status shows tc
  task automatic run(input logic [1:0] ch, input logic [1:0] ty,
    input logic [15:0] ba, input logic [7:0] n);
    int i;
    int nb;
    for (i = 0; i <= n; i++) begin
      xq.push_back({4'h1 << ch, ty == dma_port_pkg::TT_READ,
        ty == dma_port_pkg::TT_WRITE, i != n, ba + i[15:0]});
    end
    nb = 0;
    want[ch] = 1'b1;
    for (i = 0; i < 60 && nb <= n; i++) begin
      @(posedge ref_clk) #1;
      if (ack[ch] === 1'b1) nb++;
    end
    want[ch] = 1'b0;
    `CHK(nb, n + 1)
    acc(1, dma_port_pkg::PORT_CMD, 8'h01 << ch);
  endtask : run

  // No byte may be moved for this channel while it stays refused
  task automatic quiet(input logic [1:0] ch, input logic hw);
    int nb;
    nb = 0;
    want[ch] = hw;
    repeat (12) begin
      @(posedge ref_clk) #1;
      if (ack[ch] === 1'b1) nb++;
    end
    want[ch] = 1'b0;
    `CHK(nb, 0)
  endtask : quiet

  task automatic test_done;
    $display("Errors %0d, checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // Watchdog: full run needs a few hundred cycles
  initial begin
    #100000;
    error_cnt++;
    test_done;
  end

  initial begin
    {ref_clk, resetn, io_wr, io_rd, mm_on, want} = 9'h000;
    {io_addr, io_wdata} = 16'h0000;
    error_cnt = 0;
    check_count = 0;
    void'($urandom(33345));
    repeat (2) @(posedge ref_clk);
    #1 resetn = 1'b1;
    acc(1, dma_port_pkg::PORT_CMD, 8'h00);
    acc(1, dma_port_pkg::PORT_MCLR, 8'h00);
    acc(1, dma_port_pkg::PORT_REQ, 8'h00);
    quiet(2, 1);
    // Demand, single and block on channels 1..3, random type and address
    for (k = 0; k < 3; k++) begin
      tt = ($urandom % 2 == 0) ? dma_port_pkg::TT_READ : dma_port_pkg::TT_WRITE;
      a = 16'($urandom) & 16'h7FFF;
      prog(k[1:0] + 2'h1, k[1:0], tt, 1'b0, a, 8'h01);
      acc(0, dma_port_pkg::PORT_MASK_ONE, {6'h00, k[1:0] + 2'h1});
      run(k[1:0] + 2'h1, tt, a, 8'h01);
      quiet(k[1:0] + 2'h1, 1);
    end
    // Out-of-range accesses must not disturb the held read byte
    acc(0, 8'h3D, 8'h00);
    acc(1, 8'hA8, 8'h00);
    `CHK(io_rdata, 8'h08)
    // Autoinit keeps the channel open and reloads its base address
    a = 16'($urandom) & 16'h7FFF;
    prog(0, dma_port_pkg::XM_SINGLE, dma_port_pkg::TT_READ, 1'b1, a, 8'h00);
    acc(0, dma_port_pkg::PORT_MASK_ONE, 8'h00);
    run(0, dma_port_pkg::TT_READ, a, 8'h00);
    run(0, dma_port_pkg::TT_READ, a, 8'h00);
    acc(0, dma_port_pkg::PORT_MASK_ONE, 8'h04);
    quiet(0, 1);
    // Software request outside block mode is never served
    prog(3, dma_port_pkg::XM_SINGLE, dma_port_pkg::TT_READ, 1'b0, a, 8'h00);
    acc(0, dma_port_pkg::PORT_REQ, 8'h07);
    quiet(3, 0);
    acc(0, dma_port_pkg::PORT_REQ, 8'h03);
    // Memory move: two bytes from 0100 to 0200, started on channel 0
    prog(0, dma_port_pkg::XM_BLOCK, 2'h0, 1'b0, 16'h0100, 8'h01);
    prog(1, dma_port_pkg::XM_BLOCK, 2'h0, 1'b0, 16'h0200, 8'h01);
    mm_on = 1'b1;
    // Earlier write-type runs already bumped the far side's write log
    w0 = wr_cnt;
    acc(0, dma_port_pkg::PORT_CMD, 8'h01);
    acc(0, dma_port_pkg::PORT_REQ, 8'h04);
    for (k = 0; k < 60 && wr_cnt != w0 + 8'h02; k++) @(posedge ref_clk) #1;
    `CHK({8'(wr_cnt - w0), wr_addr, wr_data}, 32'h0202013D)
    acc(1, dma_port_pkg::PORT_MCLR, 8'h3D);
    acc(0, dma_port_pkg::PORT_MCLR, 8'($urandom));
    mm_on = 1'b0;
    acc(1, dma_port_pkg::PORT_MCLR, 8'h00);
    acc(1, dma_port_pkg::PORT_CMD, 8'h00);
    quiet(1, 1);
    // Four-bit mask word, then clear-all
    acc(0, dma_port_pkg::PORT_MASK_ALL, 8'h0B);
    a = 16'($urandom) & 16'h7FFF;
    prog(2, dma_port_pkg::XM_SINGLE, dma_port_pkg::TT_WRITE, 1'b0, a, 8'h00);
    run(2, dma_port_pkg::TT_WRITE, a, 8'h00);
    quiet(1, 1);
    acc(0, dma_port_pkg::PORT_MASK_CLR, 8'h00);
    run(1, 2'h0, 16'h0000, 8'h00);
    repeat (3) @(posedge ref_clk);
    `CHK(rq.size() + xq.size(), 0)
    test_done;
  end
endmodule : tb
`default_nettype wire
